// ===== verilog/branch_skip_regs.vh
// constants for the branch, skip and compare unit
`ifndef BRANCH_SKIP_REGS_VH
`define BRANCH_SKIP_REGS_VH
// status flag bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7
// operation codes on the opCode port
`define OP_NONE 5'h00
`define OP_EQUAL_SKIP 5'h01
`define OP_COMPARE_REGS 5'h02
`define OP_COMPARE_BORROW 5'h03
`define OP_COMPARE_IMM 5'h04
`define OP_SKIP_REG_ZERO 5'h05
`define OP_SKIP_REG_ONE 5'h06
`define OP_SKIP_IO_ZERO 5'h07
`define OP_SKIP_IO_ONE 5'h08
`define OP_BRANCH_FLAG_ONE 5'h09
`define OP_BRANCH_FLAG_ZERO 5'h0A
`define OP_RETURN_IRQ 5'h0B
// branch flag tests, the named branches map to these
`define OP_BRANCH_EQUAL 5'h0C
`define OP_BRANCH_UNEQUAL 5'h0D
`define OP_BRANCH_CARRY_ONE 5'h0E
`define OP_BRANCH_CARRY_ZERO 5'h0F
`define OP_BRANCH_UNSIGNED_GE 5'h10
`define OP_BRANCH_UNSIGNED_LT 5'h11
`define OP_BRANCH_NEGATIVE 5'h12
`define OP_BRANCH_NONNEGATIVE 5'h13
`define OP_BRANCH_SIGNED_GE 5'h14
`define OP_BRANCH_SIGNED_LT 5'h15
`define OP_BRANCH_NIBBLE_ONE 5'h16
`define OP_BRANCH_NIBBLE_ZERO 5'h17
`define OP_BRANCH_SPARE_ONE 5'h18
`define OP_BRANCH_SPARE_ZERO 5'h19
`define OP_BRANCH_WRAP_ONE 5'h1A
`define OP_BRANCH_WRAP_ZERO 5'h1B
// return timing in cycles, then skip pc steps
`define CYC_RETURN_IRQ 3'h4
`define SKIP_ONE_WORD 12'h002
`define SKIP_TWO_WORD 12'h003
// reset values
`define PC_RESET 12'h000
`define FLAGS_RESET 8'h00
`endif

// ===== verilog/compare_flags.v
// compare datapath: forms the difference only to update flags
`timescale 1ns/100ps
`include "branch_skip_regs.vh"
module compare_flags (
  // operands
  input wire [7:0] minuend,
  input wire [7:0] subtrahend,
  input wire useBorrow,
  input wire [7:0] flagsIn,
  // result flags
  output reg [7:0] flagsOut
);
  wire borrowIn;
  wire [7:0] diff;
  wire zeroNew;
  wire overflowNew;
  assign borrowIn = useBorrow & flagsIn[`FLAG_C];
  // overflow on its own net, so the flag process never reads its output
  assign overflowNew = (minuend[7] & ~subtrahend[7] & ~diff[7]) |
                       (~minuend[7] & subtrahend[7] & diff[7]);
  assign diff = minuend - subtrahend - {7'h00, borrowIn};
  // with borrow, zero only stays set, so multibyte compares chain
  assign zeroNew = useBorrow ? ((diff == 8'h00) & flagsIn[`FLAG_Z])
                             : (diff == 8'h00);
  // difference is discarded; only the flags leave this module
  always @* begin
    flagsOut = flagsIn;
    flagsOut[`FLAG_Z] = zeroNew;
    flagsOut[`FLAG_N] = diff[7];
    flagsOut[`FLAG_V] = overflowNew;
    flagsOut[`FLAG_C] = (~minuend[7] & subtrahend[7]) |
                        (subtrahend[7] & diff[7]) |
                        (diff[7] & ~minuend[7]);
    flagsOut[`FLAG_H] = (~minuend[3] & subtrahend[3]) |
                        (subtrahend[3] & diff[3]) |
                        (diff[3] & ~minuend[3]);
    flagsOut[`FLAG_S] = diff[7] ^ overflowNew;
  end
endmodule // compare_flags

// ===== verilog/branch_target.v
// relative branch target: program counter plus signed offset plus one
`timescale 1ns/100ps
module branch_target (
  // inputs
  input wire [11:0] pcNow,
  input wire [6:0] offset,
  // output
  output wire [11:0] target
);
  wire [11:0] offsetWide;
  // sign extension lets branches reach backward
  assign offsetWide = {{5{offset[6]}}, offset};
  assign target = pcNow + offsetWide + 12'h001;
endmodule // branch_target

// ===== verilog/branch_skip_compare_unit.v
// branch, skip and compare execution unit of an 8-bit core
`timescale 1ns/100ps
`include "branch_skip_regs.vh"
module branch_skip_compare_unit (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // instruction issue
  input wire opValid,
  input wire [4:0] opCode,
  input wire [7:0] destOperand,
  input wire [7:0] sourceOperand,
  input wire [7:0] immediate,
  input wire [2:0] bitIndex,
  input wire [6:0] offset,
  input wire nextIsTwoWord,
  // io register value read by the datapath
  input wire [7:0] ioValue,
  // stack return address
  input wire [11:0] stackPc,
  // pc load from the rest of the core
  input wire pcLoad,
  input wire [11:0] pcLoadValue,
  // flag load from the rest of the core
  input wire flagsLoad,
  input wire [7:0] flagsLoadValue,
  // results
  output reg [11:0] programCounter,
  output reg [7:0] statusFlags,
  output reg busy,
  output reg taken,
  output reg done
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_WAIT = 4'h2;
  localparam [3:0] ST_LAST = 4'h4;
  localparam [3:0] ST_RET = 4'h8;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [2:0] count_reg;
  reg [2:0] count_next;
  reg [11:0] pendPc_reg;
  reg [11:0] pendPc_next;
  reg [11:0] pc_next;
  reg [7:0] flags_next;
  reg busy_next;
  reg taken_next;
  reg done_next;

  reg condTrue;
  reg isBranch;
  reg isSkip;
  reg isCompare;
  wire [7:0] cmpFlags;
  wire [11:0] relTarget;
  wire [11:0] skipStep;
  wire [7:0] cmpSubtrahend;

  // decode: true for the fixed-flag branch codes
  function branchFlagOf;
    input [4:0] code;
    input [7:0] f;
    begin
      case (code)
        `OP_BRANCH_EQUAL: branchFlagOf = f[`FLAG_Z];
        `OP_BRANCH_UNEQUAL: branchFlagOf = ~f[`FLAG_Z];
        `OP_BRANCH_CARRY_ONE: branchFlagOf = f[`FLAG_C];
        `OP_BRANCH_CARRY_ZERO: branchFlagOf = ~f[`FLAG_C];
        `OP_BRANCH_UNSIGNED_GE: branchFlagOf = ~f[`FLAG_C];
        `OP_BRANCH_UNSIGNED_LT: branchFlagOf = f[`FLAG_C];
        `OP_BRANCH_NEGATIVE: branchFlagOf = f[`FLAG_N];
        `OP_BRANCH_NONNEGATIVE: branchFlagOf = ~f[`FLAG_N];
        `OP_BRANCH_SIGNED_GE:
          branchFlagOf = ~(f[`FLAG_N] ^ f[`FLAG_V]);
        `OP_BRANCH_SIGNED_LT:
          branchFlagOf = f[`FLAG_N] ^ f[`FLAG_V];
        `OP_BRANCH_NIBBLE_ONE: branchFlagOf = f[`FLAG_H];
        `OP_BRANCH_NIBBLE_ZERO: branchFlagOf = ~f[`FLAG_H];
        `OP_BRANCH_SPARE_ONE: branchFlagOf = f[`FLAG_T];
        `OP_BRANCH_SPARE_ZERO: branchFlagOf = ~f[`FLAG_T];
        `OP_BRANCH_WRAP_ONE: branchFlagOf = f[`FLAG_V];
        `OP_BRANCH_WRAP_ZERO: branchFlagOf = ~f[`FLAG_V];
        default: branchFlagOf = 1'b0;
      endcase
    end
  endfunction

  // selects the indexed bit; shared by register, io and flag tests
  function bitAt;
    input [7:0] v;
    input [2:0] idx;
    begin
      bitAt = v[idx];
    end
  endfunction

  // compare with immediate uses the constant as subtrahend
  assign cmpSubtrahend = (opCode == `OP_COMPARE_IMM) ? immediate
                                                     : sourceOperand;

  compare_flags u_cmp (
    .minuend(destOperand),
    .subtrahend(cmpSubtrahend),
    .useBorrow(opCode == `OP_COMPARE_BORROW),
    .flagsIn(statusFlags),
    .flagsOut(cmpFlags)
  );

  branch_target u_tgt (
    .pcNow(programCounter),
    .offset(offset),
    .target(relTarget)
  );

  // skip distance depends on the size of the skipped instruction
  assign skipStep = nextIsTwoWord ? `SKIP_TWO_WORD
                                  : `SKIP_ONE_WORD;

  // condition decode for the issued instruction
  always @* begin
    condTrue = 1'b0;
    isBranch = 1'b0;
    isSkip = 1'b0;
    isCompare = 1'b0;
    case (opCode)
      // register equality skip
      `OP_EQUAL_SKIP: begin
        isSkip = 1'b1;
        condTrue = (destOperand == sourceOperand);
      end
      // bit tests on a general register
      `OP_SKIP_REG_ZERO: begin
        isSkip = 1'b1;
        condTrue = ~bitAt(sourceOperand, bitIndex);
      end
      `OP_SKIP_REG_ONE: begin
        isSkip = 1'b1;
        condTrue = bitAt(sourceOperand, bitIndex);
      end
      // bit tests on the io value, which must be steady at issue
      `OP_SKIP_IO_ZERO: begin
        isSkip = 1'b1;
        condTrue = ~bitAt(ioValue, bitIndex);
      end
      `OP_SKIP_IO_ONE: begin
        isSkip = 1'b1;
        condTrue = bitAt(ioValue, bitIndex);
      end
      // indexed status bit branches
      `OP_BRANCH_FLAG_ONE: begin
        isBranch = 1'b1;
        condTrue = bitAt(statusFlags, bitIndex);
      end
      `OP_BRANCH_FLAG_ZERO: begin
        isBranch = 1'b1;
        condTrue = ~bitAt(statusFlags, bitIndex);
      end
      // compares only touch flags, the pc steps by one
      `OP_COMPARE_REGS, `OP_COMPARE_BORROW, `OP_COMPARE_IMM: begin
        isCompare = 1'b1;
      end
      default: begin
        isBranch = (opCode >= `OP_BRANCH_EQUAL);
        condTrue = branchFlagOf(opCode, statusFlags);
      end
    endcase
  end

  // sequencer: a taken branch or skip holds busy for its extra cycles
  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    pendPc_next = pendPc_reg;
    pc_next = programCounter;
    flags_next = statusFlags;
    busy_next = 1'b0;
    taken_next = 1'b0;
    done_next = 1'b0;
    // external flag load goes first so writes by the unit win
    if (flagsLoad) begin
      flags_next = flagsLoadValue;
    end
    case (state_reg)
      ST_IDLE: begin
        // an external pc load beats an issue in the same cycle
        if (pcLoad) begin
          pc_next = pcLoadValue;
        end else if (opValid) begin
          if (isCompare) begin
            flags_next = cmpFlags;
            pc_next = programCounter + 12'h001;
            done_next = 1'b1;
          end else if (opCode == `OP_RETURN_IRQ) begin
            pendPc_next = stackPc;
            count_next = `CYC_RETURN_IRQ - 3'h2;
            busy_next = 1'b1;
            state_next = ST_RET;
          end else if ((isBranch | isSkip) & condTrue) begin
            // pc moves at the last cycle so fetch sees one clean change
            pendPc_next = isBranch ? relTarget
                                   : programCounter + skipStep;
            count_next = (isSkip & nextIsTwoWord) ? 3'h1 : 3'h0;
            busy_next = 1'b1;
            state_next = (isSkip & nextIsTwoWord) ? ST_WAIT : ST_LAST;
          end else begin
            // not taken, or unknown code: one cycle and fall through
            pc_next = programCounter + 12'h001;
            done_next = 1'b1;
          end
        end
      end
      // a two-word skip spends one more cycle here
      ST_WAIT: begin
        busy_next = 1'b1;
        state_next = ST_LAST;
      end
      // final cycle: apply the held target and pulse done
      ST_LAST: begin
        pc_next = pendPc_reg;
        taken_next = 1'b1;
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      // return counts down while the stack value waits in pendPc
      ST_RET: begin
        if (count_reg == 3'h0) begin
          pc_next = pendPc_reg;
          flags_next[`FLAG_I] = 1'b1;
          taken_next = 1'b1;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end else begin
          busy_next = 1'b1;
          count_next = count_reg - 3'h1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // state and output flops; outputs come straight from these
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      count_reg <= 3'h0;
      pendPc_reg <= `PC_RESET;
      programCounter <= `PC_RESET;
      statusFlags <= `FLAGS_RESET;
      busy <= 1'b0;
      taken <= 1'b0;
      done <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      pendPc_reg <= pendPc_next;
      programCounter <= pc_next;
      statusFlags <= flags_next;
      busy <= busy_next;
      taken <= taken_next;
      done <= done_next;
    end
  end
endmodule // branch_skip_compare_unit

// ===== dv/operand_source.sv
// model of the core datapath feeding io and stack values
`timescale 1ns/100ps
module operand_source (
  // clock, reset and load
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [7:0] ioNew,
  input wire [11:0] stackNew,
  // values toward the unit
  output reg [7:0] ioValue,
  output reg [11:0] stackPc
);
  // values latch on load, so they stay steady through a long op
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ioValue <= 8'h00;
      stackPc <= 12'h000;
    end else if (load) begin
      ioValue <= ioNew;
      stackPc <= stackNew;
    end
  end
endmodule // operand_source

// ===== dv/bscu_checker.sv
// timing and pc checks on the unit's ports
`timescale 1ns/100ps
`include "branch_skip_regs.vh"
module bscu_checker (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // issue side
  input wire opValid,
  input wire [4:0] opCode,
  input wire [2:0] bitIndex,
  input wire [6:0] offset,
  input wire nextIsTwoWord,
  input wire [7:0] ioValue,
  input wire pcLoad,
  // results
  input wire [11:0] programCounter,
  input wire [7:0] statusFlags,
  input wire busy,
  input wire taken,
  input wire done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // an issue is only taken while idle and no pc load competes
  wire go = opValid && !busy && !pcLoad;
  compare_one_a:
  assert property (go && opCode == `OP_COMPARE_REGS |=> done && !taken
    && !busy && programCounter == $past(programCounter) + 12'h001)
    else $error("compare not single cycle");
  eq_branch_a:
  assert property (go && opCode == `OP_BRANCH_EQUAL && statusFlags[`FLAG_Z]
    |=> busy ##1 (taken && done && programCounter ==
    $past(programCounter, 2) + {{5{$past(offset[6], 2)}},
    $past(offset, 2)} + 12'h001)) else $error("equal branch wrong");
  uneq_skip_a:
  assert property (go && opCode == `OP_BRANCH_UNEQUAL
    && statusFlags[`FLAG_Z]
    |=> done && !taken && programCounter == $past(programCounter) + 12'h001)
    else $error("unequal branch taken");
  irq_return_a:
  assert property (go && opCode == `OP_RETURN_IRQ
    |=> busy [*3] ##1 (done && taken && statusFlags[`FLAG_I]))
    else $error("return not four cycles");
  io_skip_two_a:
  assert property (go && opCode == `OP_SKIP_IO_ONE && ioValue[bitIndex]
    && nextIsTwoWord |=> ##2 (done && taken
    && programCounter == $past(programCounter, 3) + 12'h003))
    else $error("two word skip wrong");
  io_skip_one_a:
  assert property (go && opCode == `OP_SKIP_IO_ZERO && !ioValue[bitIndex]
    && !nextIsTwoWord |=> ##1 (done
    && programCounter == $past(programCounter, 2) + 12'h002))
    else $error("one word skip wrong");
  busy_done_a:
  assert property (busy |-> !done) else $error("done while busy");
  busy_bound_a:
  assert property ($rose(busy) |-> ##[1:3] !busy)
    else $error("busy too long");
endmodule // bscu_checker
bind branch_skip_compare_unit bscu_checker chk_u (.clk(clk),
  .rst_n(rst_n), .opValid(opValid), .opCode(opCode),
  .bitIndex(bitIndex), .offset(offset), .nextIsTwoWord(nextIsTwoWord),
  .ioValue(ioValue), .pcLoad(pcLoad), .programCounter(programCounter),
  .statusFlags(statusFlags), .busy(busy), .taken(taken), .done(done));

// ===== dv/branch_skip_compare_unit_tb_top.sv
// self-checking bench for the branch, skip and compare unit
`timescale 1ns/100ps
`include "branch_skip_regs.vh"
module branch_skip_compare_unit_tb_top;
  reg clk, rst_n, opValid, twoWord, pcLoad, flagsLoad, srcLoad, tkExp, t;
  reg [4:0] opCode;
  reg [7:0] dOp, sOp, imm, flagsNew, ioNew, fExp;
  reg [2:0] bitIdx, latExp;
  reg [6:0] offset;
  reg [11:0] pcNew, stackNew, pcExp;
  wire [7:0] ioValue, statusFlags;
  wire [11:0] stackPc, programCounter;
  wire busy, taken, done;
  integer err_count, n_checks, i, lat;
  operand_source src_u (.clk(clk), .rst_n(rst_n), .load(srcLoad),
    .ioNew(ioNew), .stackNew(stackNew), .ioValue(ioValue),
    .stackPc(stackPc));
  branch_skip_compare_unit dut_u (.clk(clk), .rst_n(rst_n),
    .opValid(opValid), .opCode(opCode), .destOperand(dOp),
    .sourceOperand(sOp), .immediate(imm), .bitIndex(bitIdx),
    .offset(offset), .nextIsTwoWord(twoWord), .ioValue(ioValue),
    .stackPc(stackPc), .pcLoad(pcLoad), .pcLoadValue(pcNew),
    .flagsLoad(flagsLoad), .flagsLoadValue(flagsNew),
    .programCounter(programCounter), .statusFlags(statusFlags),
    .busy(busy), .taken(taken), .done(done));
  // 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task check(input [63:0] what, input [11:0] seen, input [11:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task summarize;
    begin
      if (err_count == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // compare flags: the difference is formed and then dropped
  function [7:0] cmpF(input [7:0] d, input [7:0] r, input bw,
    input [7:0] f);
    reg [8:0] x;
    reg v;
    begin
      x = {1'b0, d} - {1'b0, r} - {8'h00, bw & f[0]};
      v = (d[7] & ~r[7] & ~x[7]) | (~d[7] & r[7] & x[7]);
      cmpF = {f[7:6], (~d[3] & r[3]) | (r[3] & x[3]) | (x[3] & ~d[3]),
        x[7] ^ v, v, x[7], x[7:0] == 8'h00 && (!bw || f[1]), x[8]};
    end
  endfunction
  // branch condition; odd codes mostly negate the even partner
  function cond(input [4:0] op, input [7:0] f, input [2:0] b);
    case (op)
      `OP_BRANCH_FLAG_ONE: cond = f[b];
      `OP_BRANCH_FLAG_ZERO: cond = ~f[b];
      default: case (op[4:1])
        4'h6: cond = f[1] ^ op[0];
        4'h7: cond = f[0] ^ op[0];
        4'h8: cond = ~f[0] ^ op[0];
        4'h9: cond = f[2] ^ op[0];
        4'hA: cond = ~(f[2] ^ f[3]) ^ op[0];
        4'hB: cond = f[5] ^ op[0];
        4'hC: cond = f[6] ^ op[0];
        4'hD: cond = f[3] ^ op[0];
        default: cond = 1'b0;
      endcase
    endcase
  endfunction
  task runOp(input [4:0] op);
    begin
      @(negedge clk);
      opCode = op;
      dOp = 8'($urandom);
      sOp = ($urandom % 4 == 0) ? dOp : 8'($urandom);
      imm = 8'($urandom);
      flagsNew = 8'($urandom);
      ioNew = 8'($urandom);
      {stackNew, bitIdx, offset, twoWord} = 23'($urandom);
      flagsLoad = 1'b1;
      srcLoad = 1'b1;
      fExp = flagsNew;
      tkExp = 1'b0;
      latExp = 3'h1;
      case (op)
        `OP_EQUAL_SKIP: t = dOp == sOp;
        `OP_SKIP_REG_ZERO: t = ~sOp[bitIdx];
        `OP_SKIP_REG_ONE: t = sOp[bitIdx];
        `OP_SKIP_IO_ZERO: t = ~ioNew[bitIdx];
        `OP_SKIP_IO_ONE: t = ioNew[bitIdx];
        default: t = cond(op, fExp, bitIdx);
      endcase
      // which operand feeds the bit test is left open, so keep them equal
      if (op == `OP_SKIP_REG_ZERO || op == `OP_SKIP_REG_ONE) dOp = sOp;
      if (op == `OP_COMPARE_REGS || op == `OP_COMPARE_BORROW)
        fExp = cmpF(dOp, sOp, op == `OP_COMPARE_BORROW, fExp);
      if (op == `OP_COMPARE_IMM) fExp = cmpF(dOp, imm, 1'b0, fExp);
      if (op == `OP_RETURN_IRQ) begin
        pcExp = stackNew;
        fExp[7] = 1'b1;
        latExp = 3'h4;
        tkExp = 1'b1;
      end else if (t && op < `OP_BRANCH_FLAG_ONE) begin
        pcExp = pcExp + (twoWord ? 12'h003 : 12'h002);
        latExp = twoWord ? 3'h3 : 3'h2;
        tkExp = 1'b1;
      end else if (t) begin
        pcExp = pcExp + {{5{offset[6]}}, offset} + 12'h001;
        latExp = 3'h2;
        tkExp = 1'b1;
      end else
        pcExp = pcExp + 12'h001;
      @(negedge clk);
      flagsLoad = 1'b0;
      srcLoad = 1'b0;
      opValid = 1'b1;
      @(negedge clk);
      opValid = 1'b0;
      lat = 1;
      while (done !== 1'b1 && lat < 8) begin
        @(negedge clk);
        lat = lat + 1;
      end
      if (done !== 1'b1) begin
        err_count = err_count + 1;
        summarize;
      end
      check("cycles", lat[11:0], {9'h000, latExp});
      check("taken", {11'h000, taken}, {11'h000, tkExp});
      check("pc", programCounter, pcExp);
      check("flags", {4'h0, statusFlags}, {4'h0, fExp});
    end
  endtask
  // reset, park pc near the top so skips wrap, then every code but OP_NONE and random
  initial begin
    err_count = 0;
    n_checks = 0;
    {rst_n, opValid, twoWord, pcLoad, flagsLoad, srcLoad} = 6'h00;
    {opCode, dOp, sOp, imm, flagsNew, ioNew, bitIdx, offset} = '0;
    {pcNew, stackNew} = 24'h000000;
    i = $urandom(32'h39F4AF1A);
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    pcLoad = 1'b1;
    pcNew = 12'hFFE;
    pcExp = 12'hFFE;
    @(negedge clk);
    pcLoad = 1'b0;
    for (i = 1; i < 28; i = i + 1) runOp(i[4:0]);
    repeat (400) runOp(5'(1 + $urandom % 27));
    summarize;
  end
endmodule // branch_skip_compare_unit_tb_top
